// ### core/ipm_pkg.sv
// constants, state codes and register layout for the promotion and mode controller
package ipm_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_PROMO = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam int BIT_BOOT = 7;
   localparam int BIT_SPECIAL_MODE_FLAG = 6;
   localparam int BIT_MDA = 5;
   localparam int BIT_IRV = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // promotion codes and source order
   // ------------------------------------------------------------
   localparam logic [3:0] PROMO_RST = 4'h5;
   localparam logic [3:0] PROMO_RSVD = 4'h5;
   localparam logic [3:0] SRC_IRQ = 4'h6;
   localparam logic [15:0] SRC_USED = 16'hffdf;
   // index 0 resolves first: higher vector address wins
   localparam logic [3:0] PRIO_ORDER [15] = '{
      4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
      4'he, 4'hf, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
   // ------------------------------------------------------------
   // operating modes, special flag then select a
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_EXPANDED = 2'h1;
   localparam logic [1:0] MODE_BOOT = 2'h2;
   localparam logic [1:0] MODE_TEST = 2'h3;
   // ------------------------------------------------------------
   // restart delay after stop, in clock cycles
   // ------------------------------------------------------------
   localparam int STOP_DLY_LONG = 4064;
   localparam int STOP_DLY_SHORT = 4;
   localparam int CNT_W = 12;
   // ------------------------------------------------------------
   // low power sequencer
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      LP_RUN = 4'b0001,
      LP_WAIT = 4'b0010,
      LP_STOP = 4'b0100,
      LP_RESTART = 4'b1000
   } ipm_lp_e;
endpackage : ipm_pkg

// ### core/ipm_ctrl.sv
// interrupt promotion, mode latch and low power control with an axi4-lite slave
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module ipm_ctrl #(
   parameter int ADDR_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // ------------------------------------------------------------
   // mode pins, cpu status and interrupt sources
   // ------------------------------------------------------------
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   input wire logic cpu_i_mask,
   input wire logic cpu_x_mask,
   input wire logic cpu_stop_disable,
   input wire logic watchdog_enable,
   input wire logic restart_delay_select,
   input wire logic low_power_idle_instr,
   input wire logic stop_instr,
   input wire logic pseudo_nmi_pin_n,
   input wire logic [15:0] irq_req,
   input wire logic [15:0] irq_local_en,
   input wire logic int_rd_stb,
   input wire logic [7:0] int_rd_data,
   // ------------------------------------------------------------
   // outputs towards the core
   // ------------------------------------------------------------
   output logic irq_service,
   output logic [3:0] irq_source,
   output logic pseudo_nmi_pin_service,
   output logic stack_req,
   output logic resume_next,
   output logic cpu_halt,
   output logic osc_enable,
   output logic timer_enable,
   output logic [1:0] op_mode,
   output logic boot_rom_on,
   output logic ext_show_valid,
   output logic [7:0] ext_show_data
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic init;
      logic [3:0] promo;
      logic special_mode_flag;
      logic mode_select_a_bit;
      logic boot;
      logic internal_read_show;
      ipm_pkg::ipm_lp_e st;
      logic [ipm_pkg::CNT_W-1:0] cnt;
      logic wake_x;
      logic awok;
      logic [ADDR_W-1:0] waddr;
      logic wok;
      logic [7:0] wdat;
      logic wstb;
      logic awrdy;
      logic wrdy;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic irq_svc;
      logic [3:0] irq_src;
      logic pseudo_nmi_pin_svc;
      logic stack;
      logic resume;
      logic halt;
      logic osc_en;
      logic timer_en;
      logic show_en;
      logic [7:0] show_dat;
   } ipm_st_s;

   ipm_st_s s_q;
   ipm_st_s s_d;

   localparam logic [ipm_pkg::CNT_W-1:0] DLY_LONG =
      ipm_pkg::CNT_W'(ipm_pkg::STOP_DLY_LONG - 1);
   localparam logic [ipm_pkg::CNT_W-1:0] DLY_SHORT =
      ipm_pkg::CNT_W'(ipm_pkg::STOP_DLY_SHORT - 1);

   // ------------------------------------------------------------
   // priority resolution
   // ------------------------------------------------------------
   function automatic logic [4:0] pick_src(input logic [15:0] act, input logic [3:0] pro);
      logic [4:0] r;
      r = 5'h00;
      // walk from lowest to highest so the last hit is the winner
      for (int i = 14; i >= 0; i--) begin
         if (act[ipm_pkg::PRIO_ORDER[i]]) begin
            r = {1'b1, ipm_pkg::PRIO_ORDER[i]};
         end
      end
      if (act[pro]) begin
         r = {1'b1, pro};
      end
      return r;
   endfunction : pick_src

   logic [15:0] irq_act;
   logic [3:0] promo_eff;
   logic [4:0] pick;
   logic pseudo_nmi_pin_act;
   logic irq_unmasked;
   logic wake_any;
   logic [7:0] promo_rd;
   logic [7:0] stat_rd;

   // local enables still gate a promoted source, and the vector is untouched
   assign irq_act = irq_req & irq_local_en & ipm_pkg::SRC_USED;
   assign promo_eff = (s_q.promo == ipm_pkg::PROMO_RSVD) ? ipm_pkg::SRC_IRQ : s_q.promo;
   assign pick = pick_src(irq_act, promo_eff);
   assign pseudo_nmi_pin_act = !pseudo_nmi_pin_n && !cpu_x_mask;
   assign irq_unmasked = pick[4] && !cpu_i_mask;
   assign wake_any = irq_unmasked || pseudo_nmi_pin_act;
   assign promo_rd = {s_q.boot, s_q.special_mode_flag, s_q.mode_select_a_bit, s_q.internal_read_show, s_q.promo};
   assign stat_rd = {2'h0, s_q.timer_en, s_q.osc_en, s_q.st};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.stack = 1'b0;
      s_d.resume = 1'b0;
      // bus write channels, either order
      if (s_axi_awvalid && s_q.awrdy) begin
         s_d.awok = 1'b1;
         s_d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wrdy) begin
         s_d.wok = 1'b1;
         s_d.wdat = s_axi_wdata[7:0];
         s_d.wstb = s_axi_wstrb[0];
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.awok && s_q.wok && !s_q.bvalid) begin
         s_d.awok = 1'b0;
         s_d.wok = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = ipm_pkg::RESP_OKAY;
         if (s_q.waddr == ADDR_W'(ipm_pkg::OFF_PROMO)) begin
            if (s_q.wstb) begin
               if (cpu_i_mask) begin
                  s_d.promo = s_q.wdat[3:0];
               end
               if (s_q.special_mode_flag) begin
                  // only a clear is honoured on the special flag
                  if (!s_q.wdat[ipm_pkg::BIT_SPECIAL_MODE_FLAG]) begin
                     s_d.special_mode_flag = 1'b0;
                  end
                  s_d.mode_select_a_bit = s_q.wdat[ipm_pkg::BIT_MDA];
                  s_d.boot = s_q.wdat[ipm_pkg::BIT_BOOT];
                  s_d.internal_read_show = s_q.wdat[ipm_pkg::BIT_IRV];
               end
            end
         end else if (s_q.waddr != ADDR_W'(ipm_pkg::OFF_STAT)) begin
            s_d.bresp = ipm_pkg::RESP_SLVERR;
         end
      end
      // bus read channel
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arrdy) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = ipm_pkg::RESP_OKAY;
         if (s_axi_araddr == ADDR_W'(ipm_pkg::OFF_PROMO)) begin
            s_d.rdata = {24'h00_0000, promo_rd};
         end else if (s_axi_araddr == ADDR_W'(ipm_pkg::OFF_STAT)) begin
            s_d.rdata = {24'h00_0000, stat_rd};
         end else begin
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = ipm_pkg::RESP_SLVERR;
         end
      end
      // mode straps taken in the first cycle after reset release
      if (!s_q.init) begin
         s_d.init = 1'b1;
         s_d.special_mode_flag = !mode_pin_b;
         s_d.mode_select_a_bit = mode_pin_a;
         s_d.boot = !mode_pin_b && !mode_pin_a;
         s_d.internal_read_show = 1'b0;
      end
      if (!s_d.special_mode_flag) begin
         s_d.boot = 1'b0;
         s_d.internal_read_show = 1'b0;
      end
      // low power sequencer
      case (s_q.st)
         ipm_pkg::LP_RUN: begin
            if (low_power_idle_instr) begin
               s_d.st = ipm_pkg::LP_WAIT;
               s_d.stack = 1'b1;
            end else if (stop_instr && !cpu_stop_disable) begin
               s_d.st = ipm_pkg::LP_STOP;
            end
         end
         ipm_pkg::LP_WAIT: begin
            if (wake_any) begin
               s_d.st = ipm_pkg::LP_RUN;
            end
         end
         ipm_pkg::LP_STOP: begin
            // pin low wakes regardless of its mask bit
            if (!pseudo_nmi_pin_n || (irq_act[ipm_pkg::SRC_IRQ] && !cpu_i_mask)) begin
               s_d.st = ipm_pkg::LP_RESTART;
               s_d.wake_x = !pseudo_nmi_pin_n;
               s_d.cnt = restart_delay_select ? DLY_LONG : DLY_SHORT;
            end
         end
         ipm_pkg::LP_RESTART: begin
            if (s_q.cnt == '0) begin
               s_d.st = ipm_pkg::LP_RUN;
               s_d.resume = s_q.wake_x && cpu_x_mask;
               s_d.wake_x = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt - 1'b1;
            end
         end
         default: begin
            s_d.st = ipm_pkg::LP_RUN;
         end
      endcase
      // service requests, the pseudo nmi ahead of every maskable source
      s_d.pseudo_nmi_pin_svc = (s_d.st == ipm_pkg::LP_RUN) && pseudo_nmi_pin_act;
      s_d.irq_svc = (s_d.st == ipm_pkg::LP_RUN) && !pseudo_nmi_pin_act && irq_unmasked;
      s_d.irq_src = pick[3:0];
      s_d.halt = (s_d.st != ipm_pkg::LP_RUN);
      s_d.osc_en = (s_d.st != ipm_pkg::LP_STOP);
      // timers keep running in wait when the watchdog needs them
      s_d.timer_en = (s_d.st == ipm_pkg::LP_RUN) || (s_d.st == ipm_pkg::LP_RESTART) ||
         ((s_d.st == ipm_pkg::LP_WAIT) && !(cpu_i_mask && !watchdog_enable));
      s_d.show_en = s_d.internal_read_show && int_rd_stb;
      s_d.show_dat = s_d.show_en ? int_rd_data : 8'h00;
      s_d.awrdy = !s_d.awok && !s_d.bvalid;
      s_d.wrdy = !s_d.wok && !s_d.bvalid;
      s_d.arrdy = !s_d.rvalid;
      if (!aresetn) begin
         s_d = '0;
         s_d.promo = ipm_pkg::PROMO_RST;
         s_d.st = ipm_pkg::LP_RUN;
         s_d.osc_en = 1'b1;
         s_d.timer_en = 1'b1;
         s_d.halt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = s_q.awrdy;
   assign s_axi_wready = s_q.wrdy;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arrdy;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign irq_service = s_q.irq_svc;
   assign irq_source = s_q.irq_src;
   assign pseudo_nmi_pin_service = s_q.pseudo_nmi_pin_svc;
   assign stack_req = s_q.stack;
   assign resume_next = s_q.resume;
   assign cpu_halt = s_q.halt;
   assign osc_enable = s_q.osc_en;
   assign timer_enable = s_q.timer_en;
   assign op_mode = {s_q.special_mode_flag, s_q.mode_select_a_bit};
   assign boot_rom_on = s_q.boot;
   assign ext_show_valid = s_q.show_en;
   assign ext_show_data = s_q.show_dat;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   promo_locked_a: assert property (!cpu_i_mask |=> $stable(s_q.promo))
      else $error("promotion field changed with mask clear");
   promo_reset_a: assert property (disable iff (1'b0)
      !aresetn |=> s_q.promo == ipm_pkg::PROMO_RST)
      else $error("promotion field not reserved after reset");
   special_mode_flag_strap_a: assert property (!s_q.init |=> s_q.special_mode_flag == !$past(mode_pin_b))
      else $error("special flag not inverse of pin b");
   mda_strap_a: assert property (!s_q.init |=> s_q.mode_select_a_bit == $past(mode_pin_a))
      else $error("select a not equal to pin a");
   special_mode_flag_noset_a: assert property (s_q.init && !s_q.special_mode_flag |=> !s_q.special_mode_flag)
      else $error("special flag set by software");
   mda_locked_a: assert property (s_q.init && !s_q.special_mode_flag |=> $stable(s_q.mode_select_a_bit))
      else $error("select a changed outside special mode");
   boot_clear_a: assert property (!s_q.special_mode_flag |-> !s_q.boot && !s_q.internal_read_show)
      else $error("boot or show bit set outside special mode");
   boot_strap_a: assert property (!s_q.init ##1 1'b1
      |-> s_q.boot == (op_mode == ipm_pkg::MODE_BOOT))
      else $error("boot enable not matching bootstrap mode");
   show_bus_a: assert property (int_rd_stb |=> ext_show_valid == s_q.internal_read_show
      && ext_show_data == (s_q.internal_read_show ? $past(int_rd_data) : 8'h00))
      else $error("show bus not following visibility bit");
   wait_stack_a: assert property (s_q.st == ipm_pkg::LP_RUN && low_power_idle_instr
      |=> stack_req && cpu_halt && osc_enable)
      else $error("wait entry without stack and halt");
   wait_hold_a: assert property (s_q.st == ipm_pkg::LP_WAIT && !wake_any
      |=> s_q.st == ipm_pkg::LP_WAIT)
      else $error("wait left without unmasked interrupt");
   timer_off_a: assert property (s_q.st == ipm_pkg::LP_WAIT && cpu_i_mask && !watchdog_enable
      |=> s_q.st != ipm_pkg::LP_WAIT || !timer_enable)
      else $error("timers running in masked wait");
   stop_nop_a: assert property (s_q.st == ipm_pkg::LP_RUN && stop_instr && cpu_stop_disable
      && !low_power_idle_instr |=> s_q.st == ipm_pkg::LP_RUN)
      else $error("stop entered while disabled");
   stop_clock_a: assert property (s_q.st == ipm_pkg::LP_STOP |-> !osc_enable && cpu_halt)
      else $error("clock running in stop");
   short_dly_a: assert property (s_q.st == ipm_pkg::LP_STOP && !pseudo_nmi_pin_n
      && !restart_delay_select |=> s_q.st == ipm_pkg::LP_RESTART [*4]
      ##1 s_q.st == ipm_pkg::LP_RUN)
      else $error("short restart delay not four cycles");
   pseudo_nmi_pin_resume_a: assert property (s_q.st == ipm_pkg::LP_RESTART && s_q.cnt == '0
      && s_q.wake_x && cpu_x_mask |=> resume_next && !pseudo_nmi_pin_service)
      else $error("masked pseudo nmi did not resume");
   promo_win_a: assert property (s_q.st == ipm_pkg::LP_RUN && !low_power_idle_instr
      && !stop_instr && !cpu_i_mask && !pseudo_nmi_pin_act && irq_act[promo_eff]
      |=> irq_service && irq_source == $past(promo_eff))
      else $error("promoted source did not win");

   wait_wake_c: cover property (s_q.st == ipm_pkg::LP_WAIT ##1 s_q.st == ipm_pkg::LP_RUN);
   stop_resume_c: cover property (resume_next);
   promo_grant_c: cover property (irq_service && irq_source != ipm_pkg::SRC_IRQ);
   boot_mode_c: cover property (boot_rom_on && op_mode == ipm_pkg::MODE_BOOT);
endmodule : ipm_ctrl

// ### testbench/ipm_core_model.sv
// behavioural core model holding the condition code masks
`timescale 1ns/1ps
module ipm_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_service,
   input wire logic pseudo_nmi_pin_service,
   input wire logic i_set,
   input wire logic i_clr,
   input wire logic x_clr,
   output logic cpu_i_mask,
   output logic cpu_x_mask
);
   // masks come up set; a pseudo nmi service sets both, an irq service sets only the i mask; only software clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_i_mask <= 1'b1;
         cpu_x_mask <= 1'b1;
      end else begin
         if (pseudo_nmi_pin_service) begin
            cpu_x_mask <= 1'b1;
         end else if (x_clr) begin
            cpu_x_mask <= 1'b0;
         end
         if (irq_service || pseudo_nmi_pin_service || i_set) begin
            cpu_i_mask <= 1'b1;
         end else if (i_clr) begin
            cpu_i_mask <= 1'b0;
         end
      end
   end
endmodule : ipm_core_model

// ### testbench/tb_top.sv
// self-checking bench for the promotion, mode and low power controller
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   localparam logic [7:0] PR = ipm_pkg::OFF_PROMO;
   localparam logic [1:0] OK = ipm_pkg::RESP_OKAY;
   localparam logic [1:0] ER = ipm_pkg::RESP_SLVERR;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mode_pin_a = 1'b0;
   logic mode_pin_b = 1'b0, cpu_stop_disable = 1'b1, watchdog_enable = 1'b0, i_set = 1'b0;
   logic restart_delay_select = 1'b0, low_power_idle_instr = 1'b0, stop_instr = 1'b0;
   logic pseudo_nmi_pin_n = 1'b1, int_rd_stb = 1'b0, i_clr = 1'b0, x_clr = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [15:0] irq_req = 16'h0000, irq_local_en = 16'hffff;
   logic [7:0] int_rd_data = 8'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_i_mask;
   logic cpu_x_mask, irq_service, pseudo_nmi_pin_service, stack_req, resume_next, cpu_halt, osc_enable;
   logic timer_enable, boot_rom_on, ext_show_valid;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, op_mode;
   logic [3:0] irq_source;
   logic [7:0] ext_show_data;
   int errors = 0;
   int comparisons = 0;
   always #12.5 aclk = ~aclk;
   ipm_ctrl #(.ADDR_W(4)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .mode_pin_a, .mode_pin_b, .cpu_i_mask, .cpu_x_mask,
      .cpu_stop_disable, .watchdog_enable, .restart_delay_select, .low_power_idle_instr,
      .stop_instr, .pseudo_nmi_pin_n, .irq_req, .irq_local_en, .int_rd_stb, .int_rd_data,
      .irq_service, .irq_source, .pseudo_nmi_pin_service, .stack_req, .resume_next, .cpu_halt,
      .osc_enable, .timer_enable, .op_mode, .boot_rom_on, .ext_show_valid, .ext_show_data);
   ipm_core_model core_u (.aclk, .aresetn, .irq_service, .pseudo_nmi_pin_service, .i_set, .i_clr,
      .x_clr, .cpu_i_mask, .cpu_x_mask);
   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic finish_test();
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic x(input int n);
      repeat (n) @(posedge aclk);
   endtask : x
   // outputs are read at the edge, before that edge's own updates land
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic aw, w;
      @(posedge aclk);
      s_axi_awaddr <= a[3:0];
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (!aw && !w && s_axi_bvalid === 1'b1) begin
            break;
         end
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b0;
      chk(s_axi_bvalid, 1'b1, "write answer");
      chk(s_axi_bresp, er, "write resp");
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic ar;
      @(posedge aclk);
      s_axi_araddr <= a[3:0];
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar = 1'b1;
      n = 0;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (!ar && s_axi_rvalid === 1'b1) begin
            break;
         end
         if (ar && s_axi_arready === 1'b1) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rvalid, 1'b1, "read answer");
      chk(s_axi_rdata, ed, "read data");
      chk(s_axi_rresp, er, "read resp");
   endtask : rd
   task automatic do_reset(input logic pb, input logic pa);
      @(posedge aclk);
      aresetn <= 1'b0;
      mode_pin_b <= pb;
      mode_pin_a <= pa;
      x(16);
      chk(cpu_halt, 1'b1, "halt in reset");
      chk(osc_enable, 1'b1, "osc in reset");
      aresetn <= 1'b1;
      x(2);
   endtask : do_reset
   task automatic im(input logic set);
      @(posedge aclk);
      i_set <= set;
      i_clr <= ~set;
      @(posedge aclk);
      i_set <= 1'b0;
      i_clr <= 1'b0;
   endtask : im
   task automatic take_irq(input logic [15:0] req, input logic [3:0] src);
      int n;
      @(posedge aclk);
      irq_req <= req;
      i_clr <= 1'b1;
      @(posedge aclk);
      i_clr <= 1'b0;
      n = 0;
      while (irq_service !== 1'b1 && n < 20) begin
         @(posedge aclk);
         n++;
      end
      chk(irq_service, 1'b1, "irq service");
      chk(irq_source, src, "irq source");
      x(4);
      chk(irq_service, 1'b0, "masked after take");
      irq_req <= 16'h0000;
   endtask : take_irq
   task automatic show(input logic on);
      @(posedge aclk);
      int_rd_stb <= 1'b1;
      int_rd_data <= 8'ha5;
      @(posedge aclk);
      int_rd_stb <= 1'b0;
      @(posedge aclk);
      chk(ext_show_valid, on, "show valid");
      chk(ext_show_data, on ? 8'ha5 : 8'h00, "show data");
   endtask : show
   task automatic stop_wake(input logic dly, input int expn, input logic xm);
      int n;
      @(posedge aclk);
      x_clr <= ~xm;
      cpu_stop_disable <= 1'b0;
      restart_delay_select <= dly;
      stop_instr <= 1'b1;
      @(posedge aclk);
      x_clr <= 1'b0;
      stop_instr <= 1'b0;
      x(2);
      chk(osc_enable, 1'b0, "osc stopped");
      pseudo_nmi_pin_n <= 1'b0;
      n = 0;
      while (cpu_halt !== 1'b0 && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      chk(n, expn, "restart delay");
      chk(resume_next, xm, "resume next");
      chk(pseudo_nmi_pin_service, !xm, "pseudo_nmi_pin service");
      pseudo_nmi_pin_n <= 1'b1;
   endtask : stop_wake
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic sc_modes();
      logic [1:0] k;
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         do_reset(k[1], k[0]);
         chk(op_mode, {~k[1], k[0]}, "mode latch");
         chk(boot_rom_on, k == 2'h0, "boot rom");
      end
   endtask : sc_modes
   task automatic sc_expanded();
      @(posedge aclk);
      cpu_stop_disable <= 1'b0;
      stop_instr <= 1'b1;
      @(posedge aclk);
      stop_instr <= 1'b0;
      x(2);
      chk(osc_enable, 1'b0, "stop before reset");
      do_reset(1'b1, 1'b1);
      chk(cpu_halt, 1'b0, "run after reset");
      rd(PR, {4'h2, ipm_pkg::PROMO_RST}, OK);
      wr(PR, 8'hd5, OK);
      rd(PR, {4'h2, ipm_pkg::PROMO_RST}, OK);
   endtask : sc_expanded
   task automatic sc_regs();
      do_reset(1'b0, 1'b0);
      rd(PR, {4'hc, ipm_pkg::PROMO_RST}, OK);
      im(1'b0);
      wr(PR, 8'hc3, OK);
      rd(PR, {4'hc, ipm_pkg::PROMO_RST}, OK);
      im(1'b1);
      wr(PR, 8'h73, OK);
      rd(PR, 8'h73, OK);
      chk(op_mode, ipm_pkg::MODE_TEST, "test mode");
      show(1'b1);
      wr(PR, 8'h30, OK);
      rd(PR, 8'h20, OK);
      chk(op_mode, ipm_pkg::MODE_EXPANDED, "mode after clear");
      wr(PR, 8'hdf, OK);
      rd(PR, 8'h2f, OK);
      show(1'b0);
      wr(8'h08, 8'h00, ER);
      rd(8'h08, 8'h00, ER);
      rd(ipm_pkg::OFF_STAT, 8'h31, OK);
   endtask : sc_regs
   task automatic sc_prio();
      take_irq(16'h8040, 4'hf);
      irq_local_en <= 16'h7fff;
      take_irq(16'h8040, 4'h6);
      irq_local_en <= 16'hffff;
      take_irq(16'h0081, 4'h7);
      take_irq(16'h0011, 4'h0);
      @(posedge aclk);
      irq_req <= 16'h0020;
      im(1'b0);
      x(4);
      chk(irq_service, 1'b0, "unused code");
      irq_req <= 16'h0000;
      im(1'b1);
   endtask : sc_prio
   task automatic sc_wait();
      @(posedge aclk);
      low_power_idle_instr <= 1'b1;
      @(posedge aclk);
      low_power_idle_instr <= 1'b0;
      @(posedge aclk);
      chk(stack_req, 1'b1, "stack on wait");
      irq_req <= 16'h0080;
      x(4);
      chk(timer_enable, 1'b0, "timer off");
      watchdog_enable <= 1'b1;
      x(2);
      chk(timer_enable, 1'b1, "timer on with watchdog");
      watchdog_enable <= 1'b0;
      chk(osc_enable, 1'b1, "osc in wait");
      chk(cpu_halt, 1'b1, "masked keeps wait");
      take_irq(16'h0080, 4'h7);
      chk(cpu_halt, 1'b0, "run after wait");
   endtask : sc_wait
   task automatic sc_stop();
      @(posedge aclk);
      cpu_stop_disable <= 1'b1;
      stop_instr <= 1'b1;
      @(posedge aclk);
      stop_instr <= 1'b0;
      x(3);
      chk(cpu_halt, 1'b0, "stop disabled");
      stop_wake(1'b0, ipm_pkg::STOP_DLY_SHORT + 2, 1'b1);
      stop_wake(1'b1, ipm_pkg::STOP_DLY_LONG + 2, 1'b0);
      // external irq pending but masked must not end stop; clearing the mask does
      @(posedge aclk);
      restart_delay_select <= 1'b0;
      irq_req <= 16'h0040;
      stop_instr <= 1'b1;
      @(posedge aclk);
      stop_instr <= 1'b0;
      x(4);
      chk(osc_enable, 1'b0, "masked irq keeps stop");
      take_irq(16'h0040, 4'h6);
   endtask : sc_stop
   initial begin
      sc_modes();
      sc_expanded();
      sc_regs();
      sc_prio();
      sc_wait();
      sc_stop();
      finish_test();
   end
   // the long restart delay dominates the run; allow several times the total
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      finish_test();
   end
endmodule : tb_top
